// file: src/mctpm_pkg.sv
// Constants and types for the master clock tree and power mode block
package mctpm_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_PLL_CTL    = 8'h00;
    localparam logic [7:0] OFF_PLL_MULT   = 8'h04;
    localparam logic [7:0] OFF_PLL_STAT   = 8'h08;
    localparam logic [7:0] OFF_SYS_DIV    = 8'h0c;
    localparam logic [7:0] OFF_MSS_DIV    = 8'h10;
    localparam logic [7:0] OFF_ANA_CTL    = 8'h14;
    localparam logic [7:0] OFF_RUN_CFG    = 8'h18;
    localparam logic [7:0] OFF_RUN_GATE   = 8'h1c;
    localparam logic [7:0] OFF_SLP_GATE   = 8'h20;
    localparam logic [7:0] OFF_DSL_GATE   = 8'h24;
    localparam logic [7:0] OFF_DSL_CFG    = 8'h28;
    localparam logic [7:0] OFF_USB_CTL    = 8'h2c;
    localparam logic [7:0] OFF_CTRL_OWN   = 8'h30;
    localparam logic [7:0] OFF_MSTR_OWN   = 8'h34;
    localparam logic [7:0] OFF_IRQ_STAT   = 8'h38;
    localparam logic [7:0] OFF_IRQ_CLR    = 8'h3c;
    localparam logic [7:0] OFF_IRQ_EN     = 8'h40;
    // Field positions and widths
    localparam int DIV_W        = 3;
    localparam int SRC_BIT      = 4;
    localparam int PLLEN_BIT    = 0;
    localparam int ACG_BIT      = 0;
    localparam int OWN_BIT      = 0;
    localparam int STAT_FAIL    = 0;
    localparam int STAT_OWNER   = 1;
    localparam int SPLL_W       = 10;
    localparam int DS_SRC_LSB   = 0;
    localparam int DS_SRC_W     = 2;
    localparam int DS_DIV_LSB   = 2;
    localparam int USB_INT_W    = 6;
    localparam int USB_MULT_W   = 8;
    localparam int USB_SRC_BIT  = 8;
    localparam int IRQ_W        = 3;
    localparam int IRQ_FAIL     = 0;
    localparam int IRQ_WAKE     = 1;
    localparam int IRQ_OWNER    = 2;
    // Codes and reset values
    localparam logic [5:0] USB_BYPASS_CODE = 6'h00;
    localparam logic [1:0] DS_SLOW = 2'h0;
    localparam logic [1:0] DS_FAST = 2'h1;
    localparam logic [2:0] USB_POST_DIV = 3'h3;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    // Power modes, Gray coded along run, sleep, deep sleep
    typedef enum logic [1:0] {
        PM_RUN   = 2'b00,
        PM_SLEEP = 2'b01,
        PM_DEEP  = 2'b11
    } mctpm_mode_t;
endpackage

// file: src/mctpm_tick_div.sv
// Tick divider: one output tick per div_i+1 input ticks
`timescale 1ns/10ps
module mctpm_tick_div #(
    parameter int W = 3
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         ce_i,
    // Control
    input  wire logic         clr_i,
    input  wire logic [W-1:0] div_i,
    // Ticks
    input  wire logic         tick_i,
    output logic              tick_o
);
    logic [W-1:0] cnt_q;
    wire          wrap = cnt_q >= div_i;
    // Clear restarts a full period after a switch
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_q  <= '0;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            if (clr_i) begin
                cnt_q  <= '0;
                tick_o <= 1'b0;
            end else if (tick_i) begin
                cnt_q  <= wrap ? '0 : cnt_q + W'(1);
                tick_o <= wrap;
            end else begin
                tick_o <= 1'b0;
            end
        end
    end
endmodule

// file: src/mctpm_top.sv
// Master clock tree, missing-clock switch and power modes
// Functional notes
// - System clock source chosen by PLL enable
// - Fast internal clock watches oscillator for loss
// - Missing oscillator swaps system clock to fast
// - Clock failure signalled to NMI and control
// - Master owns PLL registers; requests transfer ownership
// - Always exactly one of run, sleep, deep
// - Deep sleep stops PLLs, control, analog clocks
// - Auto gating bit picks sleep/deep gating register
// - Master clock divided; fast clock on failure
// - System clock is PLL or oscillator divided
// - Analog clock divided; fast clock on failure
// - Deep clock from slow/fast/osc, twice divided
// - USB code zero bypass, 1-31 multiply
// - USB codes 32-63 multiply by value
// - Writing zero bypasses USB PLL to output
// - 240 MHz USB PLL divided by four
// - USB reference from external or oscillator
`timescale 1ns/10ps
module mctpm_top #(
    parameter int         GATE_W     = 16,
    parameter logic [7:0] MISS_LIMIT = 8'h20
) (
    // Clock, reset, enable
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              ce_i,
    // Avalon-MM slave
    input  wire logic [7:0]        avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [31:0]       avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    input  wire logic              avs_ctrl_cpu_i,
    output logic [31:0]            avs_readdata_o,
    output logic                   avs_waitrequest_o,
    output logic                   irq_o,
    // Clock pins, asynchronous
    input  wire logic              pll_clk_i,
    input  wire logic              external_clock_input_i,
    input  wire logic              oscillator_clock_i,
    input  wire logic              internal_fast_clock_i,
    input  wire logic              internal_slow_clock_i,
    input  wire logic              usb_pll_clk_i,
    // Power requests, same domain
    input  wire logic              sleep_req_i,
    input  wire logic              deep_sel_i,
    input  wire logic              wake_i,
    // Clock ticks out
    output logic                   system_clock_o,
    output logic                   master_subsystem_clock_o,
    output logic                   analog_system_clock_o,
    output logic                   usb_clock_o,
    // Status and enables
    output logic                   clock_failure_o,
    output logic [1:0]             power_mode_o,
    output logic                   cpu_clk_en_o,
    output logic                   main_pll_en_o,
    output logic                   usb_pll_en_o,
    output logic                   ctrl_clk_en_o,
    output logic                   analog_clk_en_o,
    output logic [GATE_W-1:0]      periph_gate_o,
    // PLL settings out
    output logic [mctpm_pkg::SPLL_W-1:0]     system_pll_multiplier_o,
    output logic [mctpm_pkg::USB_MULT_W-1:0] usb_pll_mult_o,
    output logic                   usb_pll_source_select_o,
    output logic                   usb_bypass_o
);
    localparam int NP = 6;
    localparam int DW = mctpm_pkg::DIV_W;

    // Pin synchronisers and edge detect
    wire [NP-1:0] pins = {usb_pll_clk_i, internal_slow_clock_i,
                          internal_fast_clock_i, oscillator_clock_i,
                          external_clock_input_i, pll_clk_i};
    logic [NP-1:0] s1_q, s2_q, s3_q;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else if (ce_i) begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    wire [NP-1:0] tk = s2_q & ~s3_q;
    wire pll_tk  = tk[0];
    wire ext_tk  = tk[1];
    wire osc_tk  = tk[2];
    wire fast_tk = tk[3];
    wire slow_tk = tk[4];
    wire upll_tk = tk[5];

    // Registers
    logic [31:0]       pll_ctl_q, pll_mult_q, sys_div_q, mss_div_q;
    logic [31:0]       ana_ctl_q, run_cfg_q, dsl_cfg_q, usb_ctl_q;
    logic [GATE_W-1:0] run_gate_q, slp_gate_q, dsl_gate_q;
    logic [mctpm_pkg::IRQ_W-1:0] irq_stat_q, irq_en_q;
    logic              owner_ctrl_q, fail_q, fail_sw_q;
    logic [7:0]        miss_cnt_q;
    mctpm_pkg::mctpm_mode_t mode_q, mode_d;
    wire sys_div_tk, mss_div_tk, ana_div_tk, ds_div_tk, usb_div_tk;

    // One wait cycle before every answer
    wire [7:0] ad = avs_address_i;
    wire req    = avs_read_i | avs_write_i;
    wire acc    = req & ~avs_waitrequest_o;
    wire wr     = acc & avs_write_i;
    wire [31:0] wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                         {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    wire [31:0] wdm   = avs_writedata_i & wmask;
    wire own_ok = avs_ctrl_cpu_i == owner_ctrl_q;
    wire pll_wr = wr & own_ok;
    wire a_pctl = ad == mctpm_pkg::OFF_PLL_CTL;
    wire a_pmul = ad == mctpm_pkg::OFF_PLL_MULT;
    wire a_sdiv = ad == mctpm_pkg::OFF_SYS_DIV;
    wire a_mdiv = ad == mctpm_pkg::OFF_MSS_DIV;
    wire a_ana  = ad == mctpm_pkg::OFF_ANA_CTL;
    wire a_rcfg = ad == mctpm_pkg::OFF_RUN_CFG;
    wire a_rg   = ad == mctpm_pkg::OFF_RUN_GATE;
    wire a_sg   = ad == mctpm_pkg::OFF_SLP_GATE;
    wire a_dg   = ad == mctpm_pkg::OFF_DSL_GATE;
    wire a_dcfg = ad == mctpm_pkg::OFF_DSL_CFG;
    wire a_usb  = ad == mctpm_pkg::OFF_USB_CTL;
    wire a_cown = ad == mctpm_pkg::OFF_CTRL_OWN;
    wire a_mown = ad == mctpm_pkg::OFF_MSTR_OWN;
    wire a_ien  = ad == mctpm_pkg::OFF_IRQ_EN;
    wire a_iclr = ad == mctpm_pkg::OFF_IRQ_CLR;
    wire a_stat = ad == mctpm_pkg::OFF_PLL_STAT;
    wire a_ist  = ad == mctpm_pkg::OFF_IRQ_STAT;

    // Only the non-owner may request ownership
    wire take_ctrl = wr & a_cown & avs_ctrl_cpu_i & ~owner_ctrl_q &
                     avs_writedata_i[mctpm_pkg::OWN_BIT];
    wire take_mstr = wr & a_mown & ~avs_ctrl_cpu_i & owner_ctrl_q &
                     avs_writedata_i[mctpm_pkg::OWN_BIT];

    wire [31:0] stat_rd = {30'h0, owner_ctrl_q, fail_q};
    wire [31:0] rd_mux =
        a_pctl ? pll_ctl_q  : a_pmul ? pll_mult_q :
        a_stat ? stat_rd    : a_sdiv ? sys_div_q  :
        a_mdiv ? mss_div_q  : a_ana  ? ana_ctl_q  :
        a_rcfg ? run_cfg_q  : a_dcfg ? dsl_cfg_q  :
        a_usb  ? usb_ctl_q  :
        a_rg   ? 32'(run_gate_q) : a_sg ? 32'(slp_gate_q) :
        a_dg   ? 32'(dsl_gate_q) :
        a_cown ? 32'(owner_ctrl_q) : a_mown ? {31'h0, ~owner_ctrl_q} :
        a_ist  ? 32'(irq_stat_q) : a_ien ? 32'(irq_en_q) : 32'h0;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] m,
                                          input logic [31:0] d);
        merge = (old & ~m) | d;
    endfunction

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= mctpm_pkg::RST_ZERO;
        end else if (ce_i) begin
            avs_waitrequest_o <= ~(req & avs_waitrequest_o);
            if (req & avs_waitrequest_o)
                avs_readdata_o <= avs_read_i ? rd_mux : mctpm_pkg::RST_ZERO;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pll_ctl_q  <= mctpm_pkg::RST_ZERO;
            pll_mult_q <= mctpm_pkg::RST_ZERO;
            sys_div_q  <= mctpm_pkg::RST_ZERO;
            mss_div_q  <= mctpm_pkg::RST_ZERO;
            ana_ctl_q  <= mctpm_pkg::RST_ZERO;
            run_cfg_q  <= mctpm_pkg::RST_ZERO;
            dsl_cfg_q  <= mctpm_pkg::RST_ZERO;
            usb_ctl_q  <= mctpm_pkg::RST_ZERO;
            run_gate_q <= '0;
            slp_gate_q <= '0;
            dsl_gate_q <= '0;
            irq_en_q   <= '0;
        end else if (ce_i) begin
            if (pll_wr & a_pctl) pll_ctl_q <= merge(pll_ctl_q, wmask, wdm);
            if (pll_wr & a_pmul) pll_mult_q <= merge(pll_mult_q, wmask, wdm);
            if (pll_wr & a_sdiv) sys_div_q <= merge(sys_div_q, wmask, wdm);
            if (wr & a_mdiv) mss_div_q <= merge(mss_div_q, wmask, wdm);
            if (wr & a_ana)  ana_ctl_q <= merge(ana_ctl_q, wmask, wdm);
            if (wr & a_rcfg) run_cfg_q <= merge(run_cfg_q, wmask, wdm);
            if (wr & a_dcfg) dsl_cfg_q <= merge(dsl_cfg_q, wmask, wdm);
            if (wr & a_usb)  usb_ctl_q <= merge(usb_ctl_q, wmask, wdm);
            if (wr & a_rg)
                run_gate_q <= GATE_W'(merge(32'(run_gate_q), wmask, wdm));
            if (wr & a_sg)
                slp_gate_q <= GATE_W'(merge(32'(slp_gate_q), wmask, wdm));
            if (wr & a_dg)
                dsl_gate_q <= GATE_W'(merge(32'(dsl_gate_q), wmask, wdm));
            if (wr & a_ien)
                irq_en_q <= avs_writedata_i[mctpm_pkg::IRQ_W-1:0];
        end
    end

    // Fast ticks without an oscillator edge
    wire fail_set = fast_tk & ~osc_tk & ~fail_q &
                    (miss_cnt_q == MISS_LIMIT - 8'h01);
    // Switch only between ticks, so no runt pulse escapes
    wire sw_ok    = fail_q & ~fail_sw_q & ~fast_tk & ~sys_div_tk;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            miss_cnt_q   <= '0;
            fail_q       <= 1'b0;
            fail_sw_q    <= 1'b0;
            owner_ctrl_q <= 1'b0;
        end else if (ce_i) begin
            if (osc_tk)
                miss_cnt_q <= '0;
            else if (fast_tk & ~fail_q)
                miss_cnt_q <= miss_cnt_q + 8'h01;
            // Sticky: a returning oscillator does not clear it
            if (fail_set) fail_q <= 1'b1;
            if (sw_ok) fail_sw_q <= 1'b1;
            if (take_ctrl) owner_ctrl_q <= 1'b1;
            else if (take_mstr) owner_ctrl_q <= 1'b0;
        end
    end

    // Power mode sequencing
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            mctpm_pkg::PM_RUN:
                if (sleep_req_i)
                    mode_d = deep_sel_i ? mctpm_pkg::PM_DEEP
                                        : mctpm_pkg::PM_SLEEP;
            mctpm_pkg::PM_SLEEP,
            mctpm_pkg::PM_DEEP:
                if (wake_i) mode_d = mctpm_pkg::PM_RUN;
            default: mode_d = mctpm_pkg::PM_RUN;
        endcase
    end
    wire deep_d  = mode_d == mctpm_pkg::PM_DEEP;
    wire sleep_d = mode_d == mctpm_pkg::PM_SLEEP;
    wire deep    = mode_q == mctpm_pkg::PM_DEEP;
    wire auto_clock_gating     = run_cfg_q[mctpm_pkg::ACG_BIT];
    wire [GATE_W-1:0] gate_d =
        (auto_clock_gating & sleep_d) ? slp_gate_q :
        (auto_clock_gating & deep_d)  ? dsl_gate_q : run_gate_q;

    // Clock source selection
    wire pll_en   = pll_ctl_q[mctpm_pkg::PLLEN_BIT];
    wire sys_src  = pll_en ? pll_tk : osc_tk;
    wire [1:0] ds_osc =
                    dsl_cfg_q[mctpm_pkg::DS_SRC_LSB +: mctpm_pkg::DS_SRC_W];
    wire ds_src   = ds_osc == mctpm_pkg::DS_SLOW ? slow_tk :
                    ds_osc == mctpm_pkg::DS_FAST ? fast_tk : osc_tk;
    wire [5:0] usb_code = usb_ctl_q[mctpm_pkg::USB_INT_W-1:0];
    wire usb_byp  = usb_code == mctpm_pkg::USB_BYPASS_CODE;
    wire usb_rsel = usb_ctl_q[mctpm_pkg::USB_SRC_BIT];
    wire usb_ref  = usb_rsel ? osc_tk : ext_tk;
    wire mss_in   = deep ? ds_div_tk :
                    fail_sw_q ? fast_tk :
                    mss_div_q[mctpm_pkg::SRC_BIT] ? osc_tk : system_clock_o;
    wire ana_in   = ana_ctl_q[mctpm_pkg::SRC_BIT] ? osc_tk : system_clock_o;

    mctpm_tick_div #(.W(DW)) u_sys_div (
        .clk_i  (clk_i),
        .rst_n_i(rst_n_i),
        .ce_i   (ce_i),
        .clr_i  (sw_ok),
        .div_i  (sys_div_q[DW-1:0]),
        .tick_i (sys_src),
        .tick_o (sys_div_tk)
    );
    mctpm_tick_div #(.W(DW)) u_mss_div (
        .clk_i  (clk_i),
        .rst_n_i(rst_n_i),
        .ce_i   (ce_i),
        .clr_i  (sw_ok),
        .div_i  (mss_div_q[DW-1:0]),
        .tick_i (mss_in),
        .tick_o (mss_div_tk)
    );
    mctpm_tick_div #(.W(DW)) u_ana_div (
        .clk_i  (clk_i),
        .rst_n_i(rst_n_i),
        .ce_i   (ce_i),
        .clr_i  (sw_ok),
        .div_i  (ana_ctl_q[DW-1:0]),
        .tick_i (ana_in),
        .tick_o (ana_div_tk)
    );
    mctpm_tick_div #(.W(DW)) u_ds_div (
        .clk_i  (clk_i),
        .rst_n_i(rst_n_i),
        .ce_i   (ce_i),
        .clr_i  (1'b0),
        .div_i  (dsl_cfg_q[mctpm_pkg::DS_DIV_LSB +: DW]),
        .tick_i (ds_src),
        .tick_o (ds_div_tk)
    );
    // PLL runs at 240 MHz; four-way divide gives 60 MHz
    mctpm_tick_div #(.W(DW)) u_usb_div (
        .clk_i  (clk_i),
        .rst_n_i(rst_n_i),
        .ce_i   (ce_i),
        .clr_i  (1'b0),
        .div_i  (mctpm_pkg::USB_POST_DIV),
        .tick_i (upll_tk),
        .tick_o (usb_div_tk)
    );

    // Set beats a same-cycle clear
    wire [mctpm_pkg::IRQ_W-1:0] ev;
    assign ev[mctpm_pkg::IRQ_FAIL]  = fail_set;
    assign ev[mctpm_pkg::IRQ_WAKE]  = (mode_d == mctpm_pkg::PM_RUN) &
                                      (mode_q != mctpm_pkg::PM_RUN);
    assign ev[mctpm_pkg::IRQ_OWNER] = take_ctrl | take_mstr;
    wire [mctpm_pkg::IRQ_W-1:0] iclr =
        (wr & a_iclr) ? avs_writedata_i[mctpm_pkg::IRQ_W-1:0] : '0;
    wire [mctpm_pkg::IRQ_W-1:0] ist_d = (irq_stat_q & ~iclr) | ev;

    // Registered outputs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode_q                   <= mctpm_pkg::PM_RUN;
            irq_stat_q               <= '0;
            irq_o                    <= 1'b0;
            system_clock_o           <= 1'b0;
            master_subsystem_clock_o <= 1'b0;
            analog_system_clock_o    <= 1'b0;
            usb_clock_o              <= 1'b0;
            clock_failure_o          <= 1'b0;
            power_mode_o             <= mctpm_pkg::PM_RUN;
            cpu_clk_en_o             <= 1'b1;
            main_pll_en_o            <= 1'b1;
            usb_pll_en_o             <= 1'b1;
            ctrl_clk_en_o            <= 1'b1;
            analog_clk_en_o          <= 1'b1;
            periph_gate_o            <= '0;
            system_pll_multiplier_o  <= '0;
            usb_pll_mult_o           <= '0;
            usb_pll_source_select_o  <= 1'b0;
            usb_bypass_o             <= 1'b1;
        end else if (ce_i) begin
            mode_q          <= mode_d;
            irq_stat_q      <= ist_d;
            irq_o           <= |(ist_d & irq_en_q);
            system_clock_o  <= ~deep &
                               (fail_sw_q ? fast_tk : sys_div_tk);
            master_subsystem_clock_o <= mss_div_tk;
            analog_system_clock_o    <= ~deep &
                               (fail_sw_q ? fast_tk : ana_div_tk);
            usb_clock_o     <= ~deep &
                               (usb_byp ? usb_ref : usb_div_tk);
            clock_failure_o <= fail_q | fail_set;
            power_mode_o    <= mode_d;
            cpu_clk_en_o    <= mode_d == mctpm_pkg::PM_RUN;
            main_pll_en_o   <= ~deep_d;
            usb_pll_en_o    <= ~deep_d;
            ctrl_clk_en_o   <= ~deep_d;
            analog_clk_en_o <= ~deep_d;
            periph_gate_o   <= gate_d;
            system_pll_multiplier_o <= pll_mult_q[mctpm_pkg::SPLL_W-1:0];
            usb_pll_mult_o  <= usb_ctl_q[mctpm_pkg::USB_MULT_W-1:0];
            usb_pll_source_select_o <= usb_rsel;
            usb_bypass_o    <= usb_byp;
        end
    end
endmodule

// file: verification/mctpm_monitor.sv
// Checker on the clock tree ports
`timescale 1ns/10ps
module mctpm_monitor (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    // Bus and power requests
    input wire logic       avs_read_i,
    input wire logic       avs_write_i,
    input wire logic       avs_waitrequest_o,
    input wire logic       sleep_req_i,
    input wire logic       deep_sel_i,
    input wire logic       wake_i,
    // Observed outputs
    input wire logic       system_clock_o,
    input wire logic       clock_failure_o,
    input wire logic [1:0] power_mode_o,
    input wire logic       cpu_clk_en_o,
    input wire logic       main_pll_en_o,
    input wire logic       usb_pll_en_o,
    input wire logic       ctrl_clk_en_o,
    input wire logic       analog_clk_en_o,
    input wire logic       usb_bypass_o,
    input wire logic [7:0] usb_pll_mult_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    mode_legal_a: assert property (power_mode_o inside {2'b00, 2'b01, 2'b11})
        else $error("Power mode outside three states");
    sleep_go_a: assert property (sleep_req_i && !wake_i && power_mode_o == 0
        |=> power_mode_o == {$past(deep_sel_i), 1'b1})
        else $error("Sleep request not taken");
    wake_go_a: assert property (wake_i && !sleep_req_i && power_mode_o != 0
        |=> power_mode_o == 2'b00) else $error("Wake not taken");
    cpu_run_a: assert property (cpu_clk_en_o == (power_mode_o == 2'b00))
        else $error("Cpu clock outside run");
    deep_off_a: assert property ({main_pll_en_o, usb_pll_en_o, ctrl_clk_en_o,
        analog_clk_en_o} == {4{power_mode_o != 2'b11}})
        else $error("Deep sleep enables wrong");
    deep_quiet_a: assert property (power_mode_o == 2'b11 [*2]
        |-> !system_clock_o) else $error("System tick in deep");
    fail_sticky_a: assert property (clock_failure_o |=> clock_failure_o)
        else $error("Clock failure cleared");
    bypass_code_a: assert property (usb_bypass_o ==
        (usb_pll_mult_o[5:0] == 6'h00)) else $error("Bypass code");
    ack_pulse_a: assert property ((avs_read_i || avs_write_i) &&
        avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("Bus answer timing");
    cover property (power_mode_o == 2'b11);
    cover property ($rose(clock_failure_o));
    cover property (usb_bypass_o ##1 !usb_bypass_o);
endmodule
bind mctpm_top mctpm_monitor mctpm_monitor_inst (.*);

// file: verification/mctpm_clk_src.sv
// Clock pin sources for the clock tree
`timescale 1ns/10ps
module mctpm_clk_src (
    // Source control
    input  wire logic osc_run_i,
    // Clock pins
    output logic      osc_o,
    output logic      ext_o,
    output logic      fast_o,
    output logic      slow_o,
    output logic      pll_o,
    output logic      usbp_o
);
    logic osc_q = 1'b0;
    initial {fast_o, slow_o, pll_o, usbp_o} = 4'h0;
    always #40 osc_q = ~osc_q;
    always #25 fast_o = ~fast_o;
    always #200 slow_o = ~slow_o;
    always #30 pll_o = ~pll_o;
    always #25 usbp_o = ~usbp_o;
    // A lost source stops low, as a dead crystal would
    assign osc_o = osc_q & osc_run_i;
    assign ext_o = osc_q & osc_run_i;
endmodule

// file: verification/test_mctpm_top.sv
// Clock tree tests
`timescale 1ns/10ps
module test_mctpm_top;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic [7:0] avs_address_i = 8'h00;
    logic avs_read_i = 1'b0, avs_write_i = 1'b0, avs_ctrl_cpu_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic avs_waitrequest_o, irq_o, osc_run = 1'b1;
    logic pll_clk_i, external_clock_input_i, oscillator_clock_i;
    logic internal_fast_clock_i, internal_slow_clock_i, usb_pll_clk_i;
    logic sleep_req_i = 1'b0, deep_sel_i = 1'b0, wake_i = 1'b0;
    logic system_clock_o, master_subsystem_clock_o, analog_system_clock_o;
    logic usb_clock_o, clock_failure_o, cpu_clk_en_o, main_pll_en_o;
    logic usb_pll_en_o, ctrl_clk_en_o, analog_clk_en_o, usb_bypass_o;
    logic usb_pll_source_select_o;
    logic [1:0] power_mode_o;
    logic [15:0] periph_gate_o;
    logic [9:0] system_pll_multiplier_o;
    logic [7:0] usb_pll_mult_o;
    logic [5:0] codes [5] = '{6'h00, 6'h01, 6'h1f, 6'h20, 6'h3f};
    int err_total = 0, comparisons = 0;
    int tick_n [3] = '{0, 0, 0};
    always #5 clk_i = ~clk_i;
    mctpm_top #(.MISS_LIMIT(8'h08)) mctpm_top_inst (.*);
    mctpm_clk_src mctpm_clk_src_inst (.osc_run_i(osc_run),
        .osc_o(oscillator_clock_i), .ext_o(external_clock_input_i),
        .fast_o(internal_fast_clock_i), .slow_o(internal_slow_clock_i),
        .pll_o(pll_clk_i), .usbp_o(usb_pll_clk_i));
    always_ff @(posedge clk_i) begin
        tick_n[0] <= tick_n[0] + int'(system_clock_o);
        tick_n[1] <= tick_n[1] + int'(master_subsystem_clock_o);
        tick_n[2] <= tick_n[2] + int'(usb_clock_o);
    end
    task automatic report_and_stop();
        $display("Comparisons %0d, errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // An edge passes before the next request
    task automatic bus(input logic w, c, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge clk_i);
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_ctrl_cpu_i <= c;
        avs_address_i <= a;
        avs_writedata_i <= d;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_i);
            if (avs_waitrequest_o === 1'b0) break;
        end
        if (i == 50) begin
            chk("bus answer", 32'h0, 32'h1);
            report_and_stop();
        end
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, logic [31:0] e);
        bus(1'b0, 1'b0, a, 32'h0);
        chk(nm, rd, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask
    // 8 us tick count, slack for source phase
    task automatic rate(input string nm, input int sel, e);
        int n;
        n = tick_n[sel];
        repeat (800) @(posedge clk_i);
        n = tick_n[sel] - n;
        chk(nm, 32'(n >= e - 2 && n <= e + 2), 32'h1);
    endtask
    task automatic mode(input logic slp, dsel);
        @(posedge clk_i);
        sleep_req_i <= slp;
        wake_i <= !slp;
        deep_sel_i <= dsel;
        @(posedge clk_i);
        sleep_req_i <= 1'b0;
        wake_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk("bypass", usb_bypass_o, 32'h1);
        rchk("pll ctl", mctpm_pkg::OFF_PLL_CTL, 32'h0);
        rchk("master own", mctpm_pkg::OFF_MSTR_OWN, 32'h1);
        wr(8'h80, 32'hffff_ffff);
        rchk("unmapped", 8'h80, 32'h0);
        rchk("irq clear", mctpm_pkg::OFF_IRQ_CLR, 32'h0);
        wr(mctpm_pkg::OFF_SYS_DIV, 32'h1);
        rate("sys osc", 0, 50);
        wr(mctpm_pkg::OFF_PLL_CTL, 32'h1);
        rate("sys pll", 0, 67);
        wr(mctpm_pkg::OFF_MSS_DIV, 32'h3);
        rate("mss div", 1, 17);
        foreach (codes[k]) begin
            wr(mctpm_pkg::OFF_USB_CTL, {24'h1, 2'b10, codes[k]});
            repeat (2) @(posedge clk_i);
            chk("usb mult", usb_pll_mult_o, {2'b10, codes[k]});
            chk("usb bypass", usb_bypass_o, codes[k] == 0);
            chk("usb src", usb_pll_source_select_o, 32'h1);
            rate("usb rate", 2, codes[k] == 0 ? 100 : 40);
        end
        bus(1'b1, 1'b1, mctpm_pkg::OFF_PLL_MULT, 32'h3ff);
        rchk("mult kept", mctpm_pkg::OFF_PLL_MULT, 32'h0);
        bus(1'b1, 1'b1, mctpm_pkg::OFF_CTRL_OWN, 32'h1);
        rchk("owner", mctpm_pkg::OFF_PLL_STAT, 32'h2);
        wr(mctpm_pkg::OFF_PLL_MULT, 32'h5);
        bus(1'b1, 1'b1, mctpm_pkg::OFF_PLL_MULT, 32'h123);
        rchk("ctrl mult", mctpm_pkg::OFF_PLL_MULT, 32'h123);
        chk("mult out", system_pll_multiplier_o, 32'h123);
        wr(mctpm_pkg::OFF_MSTR_OWN, 32'h1);
        rchk("owner back", mctpm_pkg::OFF_PLL_STAT, 32'h0);
        rchk("irq own", mctpm_pkg::OFF_IRQ_STAT, 32'h4);
        wr(mctpm_pkg::OFF_IRQ_CLR, 32'h7);
        rchk("irq clr", mctpm_pkg::OFF_IRQ_STAT, 32'h0);
        wr(mctpm_pkg::OFF_RUN_GATE, 32'hffff_1111);
        wr(mctpm_pkg::OFF_SLP_GATE, 32'h2222);
        wr(mctpm_pkg::OFF_DSL_GATE, 32'h3333);
        wr(mctpm_pkg::OFF_RUN_CFG, 32'h1);
        wr(mctpm_pkg::OFF_DSL_CFG, 32'h5);
        wr(mctpm_pkg::OFF_IRQ_EN, 32'h3);
        chk("run gate", periph_gate_o, 32'h1111);
        mode(1'b1, 1'b0);
        chk("sleep mode", power_mode_o, 32'h1);
        chk("sleep gate", periph_gate_o, 32'h2222);
        chk("sleep pll", main_pll_en_o, 32'h1);
        mode(1'b0, 1'b0);
        chk("wake irq", irq_o, 32'h1);
        wr(mctpm_pkg::OFF_IRQ_CLR, 32'h2);
        mode(1'b1, 1'b1);
        chk("deep mode", power_mode_o, 32'h3);
        chk("deep gate", periph_gate_o, 32'h3333);
        rate("deep sys", 0, 0);
        rate("deep mss", 1, 20);
        mode(1'b0, 1'b0);
        wr(mctpm_pkg::OFF_RUN_CFG, 32'h0);
        mode(1'b1, 1'b0);
        chk("acg off", periph_gate_o, 32'h1111);
        mode(1'b0, 1'b0);
        wr(mctpm_pkg::OFF_IRQ_CLR, 32'h7);
        osc_run <= 1'b0;
        for (int i = 0; i < 300 && clock_failure_o !== 1'b1; i++)
            @(posedge clk_i);
        chk("failure", clock_failure_o, 32'h1);
        repeat (2) @(posedge clk_i);
        chk("fail irq", irq_o, 32'h1);
        rchk("fail stat", mctpm_pkg::OFF_PLL_STAT, 32'h1);
        rate("fail sys", 0, 160);
        rate("fail mss", 1, 40);
        osc_run <= 1'b1;
        repeat (100) @(posedge clk_i);
        chk("fail sticky", clock_failure_o, 32'h1);
        report_and_stop();
    end
endmodule
